// File: rtl/cfpt_pkg.sv
// Purpose: Shared constants for the core flag and program-flow registers
// Assumes: APB slave, 32-bit data, byte addresses on word boundaries
// Notes: PC width is a module parameter elsewhere; APB address is fixed at 12 bits
`default_nettype none
package cfpt_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_FLAGS = 12'h000;
    localparam logic [11:0] OFF_PCL = 12'h004;
    localparam logic [11:0] OFF_TPL = 12'h008;
    localparam logic [11:0] OFF_TPH = 12'h00c;
    localparam logic [11:0] OFF_TRH = 12'h010;
    localparam logic [11:0] OFF_PC = 12'h014;

    // Flag bit positions in the arith_system_flags register
    localparam int BIT_C = 0;
    localparam int BIT_AC = 1;
    localparam int BIT_Z = 2;
    localparam int BIT_OV = 3;
    localparam int BIT_PDF = 4;
    localparam int BIT_TO = 5;
    localparam int BIT_CZ = 6;
    localparam int BIT_SC = 7;

    // Reset values and write masks
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] FLAGS_WR_MASK = 8'h0f;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Dummy instruction cycles inserted after a PC low byte load
    localparam logic [1:0] PCL_DUMMY_CYCLES = 2'h1;

    // Operations presented by the execution datapath
    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_ADD = 4'b0001,
        OP_ADC = 4'b0010,
        OP_SUB = 4'b0011,
        OP_SBC = 4'b0100,
        OP_AND = 4'b0101,
        OP_OR = 4'b0110,
        OP_XOR = 4'b0111,
        OP_RLC = 4'b1000,
        OP_RRC = 4'b1001
    } cfpt_op_type;
endpackage : cfpt_pkg
`default_nettype wire

// File: rtl/cfpt_flag_calc.sv
// Purpose: Combinational result and flag computation for one operation
// Assumes: Subtraction is done as a plus not b plus carry
// Notes: Carry set means no borrow for subtraction
`timescale 1ns/100ps
`default_nettype none
module cfpt_flag_calc (
    input wire cfpt_pkg::cfpt_op_type op,
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic c_in,
    output logic [7:0] res,
    output logic c_out,
    output logic ac_out,
    output logic z_out,
    output logic ov_out,
    output logic upd_arith,
    output logic upd_c,
    output logic upd_z
);
    // Sum of the low n bits with carry, one extra bit for the carry out
    function automatic logic [8:0] part_sum(input logic [7:0] x,
        input logic [7:0] y, input logic ci, input int n);
        logic [8:0] mask;
        mask = 9'h1ff >> (9 - n);
        part_sum = ({1'b0, x} & mask) + ({1'b0, y} & mask) + {8'h00, ci};
    endfunction : part_sum

    logic [7:0] opb;
    logic ci;
    logic [8:0] s4;
    logic [8:0] s7;
    logic [8:0] s8;

    // Operand and carry selection; subtract inverts b
    always_comb begin
        opb = b;
        ci = 1'b0;
        case (op)
            cfpt_pkg::OP_ADC: ci = c_in;
            cfpt_pkg::OP_SUB: begin
                opb = ~b;
                ci = 1'b1;
            end
            cfpt_pkg::OP_SBC: begin
                opb = ~b;
                ci = c_in;
            end
            default: ci = 1'b0;
        endcase
        s4 = part_sum(a, opb, ci, 4);
        s7 = part_sum(a, opb, ci, 7);
        s8 = part_sum(a, opb, ci, 8);
    end

    // Result and flags per operation class
    always_comb begin
        res = s8[7:0];
        c_out = s8[8];
        ac_out = s4[4];
        ov_out = s7[7] ^ s8[8];
        upd_arith = 1'b0;
        upd_c = 1'b0;
        upd_z = 1'b0;
        case (op)
            cfpt_pkg::OP_ADD, cfpt_pkg::OP_ADC,
            cfpt_pkg::OP_SUB, cfpt_pkg::OP_SBC: begin
                upd_arith = 1'b1;
                upd_c = 1'b1;
                upd_z = 1'b1;
            end
            cfpt_pkg::OP_AND: begin
                res = a & b;
                upd_z = 1'b1;
            end
            cfpt_pkg::OP_OR: begin
                res = a | b;
                upd_z = 1'b1;
            end
            cfpt_pkg::OP_XOR: begin
                res = a ^ b;
                upd_z = 1'b1;
            end
            cfpt_pkg::OP_RLC: begin
                res = {a[6:0], c_in};
                c_out = a[7];
                upd_c = 1'b1;
            end
            cfpt_pkg::OP_RRC: begin
                res = {c_in, a[7:1]};
                c_out = a[0];
                upd_c = 1'b1;
            end
            default: res = a;
        endcase
        z_out = (res == 8'h00);
    end
endmodule : cfpt_flag_calc
`default_nettype wire

// File: rtl/cfpt_pc_unit.sv
// Purpose: Program counter with low byte load and dummy cycle
// Assumes: Step and load strobes are one cycle wide
// Notes: A load wins over a step in the same cycle
`timescale 1ns/100ps
`default_nettype none
module cfpt_pc_unit #(
    parameter int PC_W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step,
    input wire logic load_stb,
    input wire logic [7:0] load_low,
    output logic [PC_W-1:0] pc_q,
    output logic dummy_q
);
    logic [PC_W-1:0] pc_d;
    logic [1:0] dcnt_q;
    logic [1:0] dcnt_d;
    logic dummy_d;

    // Load replaces only the low byte, so the jump stays in the page
    always_comb begin
        pc_d = pc_q;
        dcnt_d = dcnt_q;
        if (load_stb) begin
            pc_d = {pc_q[PC_W-1:8], load_low};
            dcnt_d = cfpt_pkg::PCL_DUMMY_CYCLES;
        end else if (dcnt_q != 2'h0) begin
            dcnt_d = dcnt_q - 2'h1;
        end else if (step) begin
            pc_d = pc_q + {{(PC_W-1){1'b0}}, 1'b1};
        end
        dummy_d = (dcnt_d != 2'h0);
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= '0;
            dcnt_q <= 2'h0;
            dummy_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            dcnt_q <= dcnt_d;
            dummy_q <= dummy_d;
        end
    end
endmodule : cfpt_pc_unit
`default_nettype wire

// File: rtl/cfpt_top.sv
// Purpose: Status flags, PC low byte and table lookup registers over APB
// Assumes: Decoder strobes are single cycle; APB master keeps the protocol
// Notes: One access-phase cycle per transfer, no wait states beyond it
`timescale 1ns/100ps
`default_nettype none
module cfpt_top #(
    parameter int PC_W = 13
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alu_valid,
    input wire cfpt_pkg::cfpt_op_type alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    output logic [7:0] alu_result,
    output logic [7:0] flags_out,
    input wire logic watchdog_kick_instr,
    input wire logic sleep_instr,
    input wire logic wdt_expire_pulse,
    input wire logic pc_step,
    output logic [PC_W-1:0] pc_value,
    output logic pc_dummy,
    input wire logic tbl_ptr_inc,
    input wire logic tbl_ptr_dec,
    input wire logic tbl_read_stb,
    output logic tbl_fetch_req,
    output logic [15:0] tbl_fetch_addr,
    input wire logic prog_word_valid,
    input wire logic [15:0] prog_word,
    output logic [7:0] tbl_low_byte,
    output logic tbl_low_valid
);
    logic [7:0] flags_q, flags_d;
    logic [7:0] tpl_q, tpl_d, tph_q, tph_d, trh_q, trh_d;
    logic [7:0] res_q, res_d, tlow_q, tlow_d;
    logic tlow_vld_q, tlow_vld_d, treq_q, treq_d;
    logic [15:0] taddr_q, taddr_d, tptr;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic setup, wr_fire, hit;
    logic [7:0] rd_val;
    logic [7:0] c_res;
    logic c_c, c_ac, c_z, c_ov, c_arith, c_updc, c_updz;
    logic wr_pcl;

    assign setup = psel & ~penable;
    assign wr_fire = psel & penable & pready & pwrite & hit;
    assign wr_pcl = wr_fire & (paddr == cfpt_pkg::OFF_PCL);
    assign tptr = {tph_q, tpl_q};

    cfpt_flag_calc u_calc (
        .op(alu_op),
        .a(alu_a),
        .b(alu_b),
        .c_in(flags_q[cfpt_pkg::BIT_C]),
        .res(c_res),
        .c_out(c_c),
        .ac_out(c_ac),
        .z_out(c_z),
        .ov_out(c_ov),
        .upd_arith(c_arith),
        .upd_c(c_updc),
        .upd_z(c_updz)
    );

    cfpt_pc_unit #(.PC_W(PC_W)) u_pc (
        .pclk(pclk),
        .presetn(presetn),
        .step(pc_step),
        .load_stb(wr_pcl),
        .load_low(pwdata[7:0]),
        .pc_q(pc_value),
        .dummy_q(pc_dummy)
    );

    // Read mux and address hit, plain chain on the held address
    always_comb begin
        hit = 1'b1;
        rd_val = 8'h00;
        if (paddr == cfpt_pkg::OFF_FLAGS) begin
            rd_val = flags_q;
        end else if (paddr == cfpt_pkg::OFF_PCL) begin
            rd_val = pc_value[7:0];
        end else if (paddr == cfpt_pkg::OFF_TPL) begin
            rd_val = tpl_q;
        end else if (paddr == cfpt_pkg::OFF_TPH) begin
            rd_val = tph_q;
        end else if (paddr == cfpt_pkg::OFF_TRH) begin
            rd_val = trh_q;
        end else if (paddr == cfpt_pkg::OFF_PC) begin
            rd_val = 8'h00;
        end else begin
            hit = 1'b0;
        end
    end

    // APB answer: data and ready registered in setup, ready for one cycle
    always_comb begin
        pready_d = setup;
        pslverr_d = setup & ~hit;
        prdata_d = prdata;
        if (setup) begin
            prdata_d = {24'h000000, rd_val};
            if (paddr == cfpt_pkg::OFF_PC) begin
                prdata_d = 32'(pc_value);
            end
        end
    end

    // Status flags; datapath update beats a same-cycle software write
    always_comb begin
        flags_d = flags_q;
        if (wr_fire && paddr == cfpt_pkg::OFF_FLAGS) begin
            flags_d = (flags_q & ~cfpt_pkg::FLAGS_WR_MASK)
                | (pwdata[7:0] & cfpt_pkg::FLAGS_WR_MASK);
        end
        if (alu_valid) begin
            if (c_updc) flags_d[cfpt_pkg::BIT_C] = c_c;
            if (c_updz) flags_d[cfpt_pkg::BIT_Z] = c_z;
            if (c_arith) begin
                flags_d[cfpt_pkg::BIT_AC] = c_ac;
                flags_d[cfpt_pkg::BIT_OV] = c_ov;
                flags_d[cfpt_pkg::BIT_SC] = c_ov ^ c_res[7];
            end
            if (alu_op == cfpt_pkg::OP_SUB) begin
                flags_d[cfpt_pkg::BIT_CZ] = c_z;
            end else if (alu_op == cfpt_pkg::OP_SBC) begin
                flags_d[cfpt_pkg::BIT_CZ] =
                    flags_q[cfpt_pkg::BIT_CZ] & c_z;
            end
        end
        // Events: a set in the same cycle as a clear wins
        if (watchdog_kick_instr || sleep_instr) begin
            flags_d[cfpt_pkg::BIT_TO] = 1'b0;
        end
        if (wdt_expire_pulse) flags_d[cfpt_pkg::BIT_TO] = 1'b1;
        if (watchdog_kick_instr) flags_d[cfpt_pkg::BIT_PDF] = 1'b0;
        if (sleep_instr) flags_d[cfpt_pkg::BIT_PDF] = 1'b1;
    end

    // Table pointer and table read; no stack path exists for status
    always_comb begin
        tpl_d = tpl_q;
        tph_d = tph_q;
        trh_d = trh_q;
        taddr_d = taddr_q;
        treq_d = 1'b0;
        tlow_d = tlow_q;
        tlow_vld_d = 1'b0;
        res_d = alu_valid ? c_res : res_q;
        if (tbl_ptr_inc) begin
            {tph_d, tpl_d} = tptr + 16'h0001;
        end else if (tbl_ptr_dec) begin
            {tph_d, tpl_d} = tptr - 16'h0001;
        end
        if (wr_fire && paddr == cfpt_pkg::OFF_TPL) tpl_d = pwdata[7:0];
        if (wr_fire && paddr == cfpt_pkg::OFF_TPH) tph_d = pwdata[7:0];
        if (tbl_read_stb) begin
            taddr_d = tptr;
            treq_d = 1'b1;
        end
        if (prog_word_valid) begin
            trh_d = prog_word[15:8];
            tlow_d = prog_word[7:0];
            tlow_vld_d = 1'b1;
        end
    end

    // Registers of this block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= cfpt_pkg::FLAGS_RST;
            tpl_q <= cfpt_pkg::BYTE_RST;
            tph_q <= cfpt_pkg::BYTE_RST;
            trh_q <= cfpt_pkg::BYTE_RST;
            taddr_q <= 16'h0000;
            treq_q <= 1'b0;
            tlow_q <= cfpt_pkg::BYTE_RST;
            tlow_vld_q <= 1'b0;
            res_q <= cfpt_pkg::BYTE_RST;
            prdata <= cfpt_pkg::RDATA_RST;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            flags_q <= flags_d;
            tpl_q <= tpl_d;
            tph_q <= tph_d;
            trh_q <= trh_d;
            taddr_q <= taddr_d;
            treq_q <= treq_d;
            tlow_q <= tlow_d;
            tlow_vld_q <= tlow_vld_d;
            res_q <= res_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // Output copies of registers
    always_comb begin
        flags_out = flags_q;
        alu_result = res_q;
        tbl_fetch_req = treq_q;
        tbl_fetch_addr = taddr_q;
        tbl_low_byte = tlow_q;
        tbl_low_valid = tlow_vld_q;
    end

    // Checks on the flag, PC and table behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sys_keep_a: assert property (
        (wr_fire && paddr == cfpt_pkg::OFF_FLAGS && !watchdog_kick_instr
         && !sleep_instr && !wdt_expire_pulse)
        |=> flags_q[5:4] == $past(flags_q[5:4]))
        else $error("status write altered watchdog or sleep flag");
    to_set_a: assert property (
        wdt_expire_pulse |=> flags_q[cfpt_pkg::BIT_TO])
        else $error("watchdog flag not set by expiry");
    to_clr_a: assert property (
        (watchdog_kick_instr || sleep_instr) && !wdt_expire_pulse
        |=> !flags_q[cfpt_pkg::BIT_TO])
        else $error("watchdog flag not cleared");
    pdf_flag_a: assert property (
        (sleep_instr |=> flags_q[cfpt_pkg::BIT_PDF]) and
        (watchdog_kick_instr && !sleep_instr
         |=> !flags_q[cfpt_pkg::BIT_PDF]))
        else $error("sleep flag wrong");
    add_flags_a: assert property (
        alu_valid && alu_op == cfpt_pkg::OP_ADD
        |=> flags_q[cfpt_pkg::BIT_C] ==
            ((9'($past(alu_a)) + 9'($past(alu_b))) > 9'h0ff))
        else $error("carry wrong after add");
    sc_xor_a: assert property (
        alu_valid && c_arith |=> flags_q[cfpt_pkg::BIT_SC] ==
            (flags_q[cfpt_pkg::BIT_OV] ^ res_q[7]))
        else $error("sign flag not ov xor msb");
    cz_sub_a: assert property (
        alu_valid && alu_op == cfpt_pkg::OP_SUB
        |=> flags_q[cfpt_pkg::BIT_CZ] == flags_q[cfpt_pkg::BIT_Z])
        else $error("chained zero differs after sub");
    cz_sbc_a: assert property (
        alu_valid && alu_op == cfpt_pkg::OP_SBC
        |=> flags_q[cfpt_pkg::BIT_CZ] == ($past(flags_q[cfpt_pkg::BIT_CZ])
            && flags_q[cfpt_pkg::BIT_Z]))
        else $error("chained zero not anded after sbc");
    pcl_jump_a: assert property (
        wr_pcl |=> pc_value[7:0] == $past(pwdata[7:0])
            && pc_value[PC_W-1:8] == $past(pc_value[PC_W-1:8]))
        else $error("pc low load wrong or left page");
    pcl_dummy_a: assert property (
        wr_pcl && !pc_dummy |=> pc_dummy ##1 !pc_dummy)
        else $error("dummy cycle not one cycle");
    trh_load_a: assert property (
        prog_word_valid |=> trh_q == $past(prog_word[15:8])
            && tbl_low_valid && tbl_low_byte == $past(prog_word[7:0]))
        else $error("table read bytes misplaced");

    pcl_jump_c: cover property (wr_pcl ##2 pc_step);
    sbc_chain_c: cover property (alu_valid && alu_op == cfpt_pkg::OP_SUB
        ##1 alu_valid && alu_op == cfpt_pkg::OP_SBC);
    tbl_read_c: cover property (tbl_read_stb ##[1:4] prog_word_valid);
    to_race_c: cover property (wdt_expire_pulse && watchdog_kick_instr);
endmodule : cfpt_top
`default_nettype wire

// File: testbench/cfpt_pmem_model.sv
// Purpose: Program memory model answering table fetches
// Assumes: One fetch outstanding at a time
// Notes: Word pattern is address xor a55a; bus toggles when idle
`timescale 1ns/100ps
`default_nettype none
module cfpt_pmem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    input wire logic [3:0] lat,
    output var logic word_valid,
    output var logic [15:0] word
);
    logic busy;
    logic [3:0] cnt;
    logic [15:0] addr_q;

    // Latency is set per fetch so both quick and slow answers occur
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            addr_q <= 16'h0000;
            word_valid <= 1'b0;
            word <= 16'h0000;
        end else begin
            word_valid <= 1'b0;
            word <= ~word; // Idle bus never holds a stale word
            if (fetch_req) begin
                busy <= 1'b1;
                cnt <= lat;
                addr_q <= fetch_addr;
            end else if (busy && cnt == 4'h0) begin
                busy <= 1'b0;
                word_valid <= 1'b1;
                word <= addr_q ^ 16'ha55a;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule : cfpt_pmem_model
`default_nettype wire

// File: testbench/cfpt_tb_top.sv
// Purpose: Self-checking bench for flags, PC low byte and table registers
// Assumes: Zero-wait APB slave, program memory model at the far side
// Notes: Expected flags are recomputed here from the operands
`timescale 1ns/100ps
`default_nettype none
module cfpt_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, re, alu_valid = 1'b0;
    cfpt_pkg::cfpt_op_type alu_op = cfpt_pkg::OP_NONE;
    logic [7:0] alu_a = 8'h00, alu_b = 8'h00, alu_result, flags_out;
    logic [7:0] ef = 8'h00, er = 8'h00, lowb;
    logic kick = 1'b0, slp = 1'b0, wdx = 1'b0, pc_step = 1'b0;
    logic inc = 1'b0, dec = 1'b0, tstb = 1'b0, pc_dummy, freq, pwv, lowv;
    logic [12:0] pc_value;
    logic [15:0] faddr, pword;
    logic [3:0] lat = 4'h0;
    int err_total = 0, tests_run = 0, n;

    always #2.5 pclk = ~pclk;

    cfpt_top #(.PC_W(13)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alu_valid(alu_valid), .alu_op(alu_op),
        .alu_a(alu_a), .alu_b(alu_b), .alu_result(alu_result),
        .flags_out(flags_out), .watchdog_kick_instr(kick),
        .sleep_instr(slp), .wdt_expire_pulse(wdx), .pc_step(pc_step),
        .pc_value(pc_value), .pc_dummy(pc_dummy), .tbl_ptr_inc(inc),
        .tbl_ptr_dec(dec), .tbl_read_stb(tstb), .tbl_fetch_req(freq),
        .tbl_fetch_addr(faddr), .prog_word_valid(pwv), .prog_word(pword),
        .tbl_low_byte(lowb), .tbl_low_valid(lowv));

    cfpt_pmem_model mem_u (.pclk(pclk), .presetn(presetn),
        .fetch_req(freq), .fetch_addr(faddr), .lat(lat),
        .word_valid(pwv), .word(pword));

    // Verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    // A used-up wait bound counts as a mismatch and ends the run
    task automatic hang(input int k);
        if (k >= 40) begin
            err_total++;
            results();
        end
    endtask : hang

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        hang(k);
    endtask : apb

    // One datapath operation, with the flag model updated alongside
    task automatic alu(input cfpt_pkg::cfpt_op_type op,
                       input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [7:0] bb, m;
        logic [4:0] lo;
        logic ci;
        case (op)
            cfpt_pkg::OP_ADD, cfpt_pkg::OP_ADC,
            cfpt_pkg::OP_SUB, cfpt_pkg::OP_SBC: begin
                bb = (op == cfpt_pkg::OP_SUB || op == cfpt_pkg::OP_SBC)
                    ? ~b : b;
                ci = (op == cfpt_pkg::OP_ADD) ? 1'b0
                    : (op == cfpt_pkg::OP_SUB) ? 1'b1 : ef[0];
                s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
                lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
                m = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
                er = s[7:0];
                ef[0] = s[8];
                ef[1] = lo[4];
                ef[2] = (er == 8'h00);
                ef[3] = m[7] ^ s[8];
                ef[7] = ef[3] ^ er[7];
                if (op == cfpt_pkg::OP_SUB) ef[6] = ef[2];
                if (op == cfpt_pkg::OP_SBC) ef[6] = ef[6] & ef[2];
            end
            cfpt_pkg::OP_AND, cfpt_pkg::OP_OR, cfpt_pkg::OP_XOR: begin
                er = (op == cfpt_pkg::OP_AND) ? (a & b)
                    : (op == cfpt_pkg::OP_OR) ? (a | b) : (a ^ b);
                ef[2] = (er == 8'h00);
            end
            cfpt_pkg::OP_RLC: begin
                er = {a[6:0], ef[0]};
                ef[0] = a[7];
            end
            cfpt_pkg::OP_RRC: begin
                er = {ef[0], a[7:1]};
                ef[0] = a[0];
            end
            default: er = a; // No-op passes operand a through
        endcase
        @(posedge pclk);
        alu_valid <= 1'b1;
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        @(posedge pclk);
        alu_valid <= 1'b0;
        #1;
        chk("flags_out", 32'(ef), 32'(flags_out));
        chk("alu_result", 32'(er), 32'(alu_result));
    endtask : alu

    // Kick, sleep and expiry strobes; setting beats clearing
    task automatic ev(input logic k, input logic s, input logic w);
        @(posedge pclk);
        kick <= k;
        slp <= s;
        wdx <= w;
        @(posedge pclk);
        kick <= 1'b0;
        slp <= 1'b0;
        wdx <= 1'b0;
        #1;
        ef[5] = w ? 1'b1 : (k | s) ? 1'b0 : ef[5];
        ef[4] = s ? 1'b1 : k ? 1'b0 : ef[4];
        chk("event_flags", 32'(ef), 32'(flags_out));
    endtask : ev

    task automatic tp(input logic i, input logic d);
        @(posedge pclk);
        inc <= i;
        dec <= d;
        @(posedge pclk);
        inc <= 1'b0;
        dec <= 1'b0;
    endtask : tp

    // Table read with a chosen memory latency
    task automatic trd(input logic [3:0] l, input logic [15:0] ad);
        int k;
        @(posedge pclk);
        tstb <= 1'b1;
        lat <= l;
        @(posedge pclk);
        tstb <= 1'b0;
        for (k = 0; k < 40; k++) begin
            #1;
            if (freq === 1'b1) break;
            @(posedge pclk);
        end
        hang(k);
        chk("fetch_addr", 32'(ad), 32'(faddr));
        for (k = 0; k < 40; k++) begin
            @(posedge pclk);
            #1;
            if (lowv === 1'b1) break;
        end
        hang(k);
        chk("low_byte", 32'(ad[7:0] ^ 8'h5a), 32'(lowb));
        apb(1'b0, cfpt_pkg::OFF_TRH, 32'h0);
        chk("high_byte", 32'(ad[15:8] ^ 8'ha5), rd);
    endtask : trd

    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk("flags_rst", 32'(cfpt_pkg::FLAGS_RST), 32'(flags_out));
        chk("pc_rst", 32'h0, 32'(pc_value));
        apb(1'b1, cfpt_pkg::OFF_FLAGS, 32'hff);
        ef[3:0] = 4'hf;
        apb(1'b0, cfpt_pkg::OFF_FLAGS, 32'h0);
        chk("flags_wr", 32'(ef), rd);
        alu(cfpt_pkg::OP_ADD, 8'h7f, 8'h01);
        alu(cfpt_pkg::OP_ADD, 8'hff, 8'h01);
        alu(cfpt_pkg::OP_ADC, 8'h0e, 8'h01);
        alu(cfpt_pkg::OP_SUB, 8'h05, 8'h05);
        alu(cfpt_pkg::OP_SBC, 8'h00, 8'h00);
        alu(cfpt_pkg::OP_SBC, 8'h00, 8'h01);
        alu(cfpt_pkg::OP_SBC, 8'h01, 8'h00);
        alu(cfpt_pkg::OP_SUB, 8'h80, 8'h01);
        alu(cfpt_pkg::OP_AND, 8'hf0, 8'h0f);
        alu(cfpt_pkg::OP_OR, 8'h80, 8'h00);
        alu(cfpt_pkg::OP_XOR, 8'h55, 8'h55);
        alu(cfpt_pkg::OP_RLC, 8'h81, 8'h00);
        alu(cfpt_pkg::OP_RRC, 8'h02, 8'h00);
        alu(cfpt_pkg::OP_NONE, 8'h12, 8'h34);
        ev(1'b0, 1'b0, 1'b1);
        apb(1'b1, cfpt_pkg::OFF_FLAGS, 32'h0);
        ef[3:0] = 4'h0;
        apb(1'b0, cfpt_pkg::OFF_FLAGS, 32'h0);
        chk("flags_keep", 32'(ef), rd);
        ev(1'b0, 1'b1, 1'b0);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b1, 1'b0, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", 32'h1, 32'(re));
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, cfpt_pkg::OFF_TRH, 32'hab);
        chk("ro_err", 32'h0, 32'(re));
        apb(1'b0, cfpt_pkg::OFF_TRH, 32'h0);
        chk("ro_keep", 32'h0, rd);
        // PC runs 300 steps so the page bits are not zero
        @(posedge pclk);
        pc_step <= 1'b1;
        repeat (300) @(posedge pclk);
        pc_step <= 1'b0;
        apb(1'b0, cfpt_pkg::OFF_PC, 32'h0);
        chk("pc_steps", 32'h12c, rd);
        apb(1'b1, 12'h004, 32'h5a);
        n = 0;
        repeat (4) begin
            #1;
            if (pc_dummy === 1'b1) n++;
            @(posedge pclk);
        end
        chk("dummy_cycles", 32'h1, 32'(n));
        chk("pc_jump", 32'h15a, 32'(pc_value));
        // Steps continue through the load; the dummy cycle swallows one
        @(posedge pclk);
        pc_step <= 1'b1;
        apb(1'b1, 12'h004, 32'h80);
        repeat (3) @(posedge pclk);
        #1;
        chk("pc_after_dummy", 32'h182, 32'(pc_value));
        @(posedge pclk);
        pc_step <= 1'b0;
        apb(1'b1, cfpt_pkg::OFF_TPL, 32'hff);
        apb(1'b1, cfpt_pkg::OFF_TPH, 32'h12);
        trd(4'h0, 16'h12ff);
        tp(1'b1, 1'b0);
        apb(1'b0, cfpt_pkg::OFF_TPL, 32'h0);
        chk("ptr_low_inc", 32'h0, rd);
        apb(1'b0, cfpt_pkg::OFF_TPH, 32'h0);
        chk("ptr_high_inc", 32'h13, rd);
        trd(4'h5, 16'h1300);
        tp(1'b0, 1'b1);
        trd(4'h2, 16'h12ff);
        results();
    end
endmodule : cfpt_tb_top
`default_nettype wire
